// ### inc/sbtc_pkg.sv
// Package for the sixteen-bit timer/counter: register map, control fields,
// reset values and the Wishbone word addressing.
// Assumes a 32-bit classic Wishbone slave port, byte-wide registers at word addresses.
package sbtc_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_COUNT_LOW = 8'h0e;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h0f;
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam int ADDR_LSB = 2;
  // ==========================================================
  // Control field positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CLKSEL = 1;
  localparam int CTL_NOSYNC = 2;
  localparam int CTL_OSCEN = 3;
  localparam int CTL_PRE_LO = 4;
  localparam int CTL_PRE_HI = 5;
  localparam logic [7:0] CTL_WR_MASK = 8'h3f;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // Interrupt status bit for overflow
  localparam int IRQ_OVF = 0;
  localparam logic [2:0] PRE_ZERO = 3'h0;
  localparam logic [2:0] PRE_ONE = 3'h1;
  // Port B bits that the oscillator takes over
  localparam logic [7:0] PORTB_OSC_PINS = 8'h06;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
endpackage

// ### logic/sbtc_prescaler.sv
// Input prescaler of the timer/counter: passes 1 of every 1, 2, 4 or 8 ticks.
// Assumes tick_i is a one-cycle pulse in the clk_i domain.
`timescale 1ns/10ps
module sbtc_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [1:0] select_i,
  output logic tick_o
);
  typedef struct packed {
    logic [2:0] cnt;
  } sbtc_pre_state_t;
  sbtc_pre_state_t st_ff;
  sbtc_pre_state_t nxt_st;
  logic [2:0] limit;

  // ==========================================================
  // Division: code 11 by eight, 10 by four, 01 by two, 00 every tick
  always_comb begin
    case (select_i)
      2'b11: limit = 3'h7;
      2'b10: limit = 3'h3;
      2'b01: limit = 3'h1;
      default: limit = sbtc_pkg::PRE_ZERO;
    endcase
    nxt_st = st_ff;
    tick_o = 1'b0;
    if (clear_i) begin
      nxt_st.cnt = sbtc_pkg::PRE_ZERO;
    end else if (tick_i) begin
      if (st_ff.cnt >= limit) begin
        nxt_st.cnt = sbtc_pkg::PRE_ZERO;
        tick_o = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + sbtc_pkg::PRE_ONE;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // sbtc_prescaler

// ### logic/sbtc_timer.sv
// Sixteen-bit timer/counter with classic Wishbone register slave.
// Assumes one clock; the external count pin is sampled on clk_i.
//
// Behaviour
// - The count is sixteen bits, a high byte over a low byte.
// - Both count bytes are readable and a write replaces the byte.
// - Rolling from all ones to zero sets the overflow flag.
// - Control bit 0 set lets the counter advance, cleared holds it.
// - Control bit 1 picks instruction-cycle ticks (0) or external rising edges (1).
// - Timer mode counts once per instruction cycle through the prescaler.
// - Control bit 3 enables the low-power oscillator, off otherwise.
// - While the oscillator runs, port B pins 2 and 1 are forced to inputs.
// - In counter mode control bit 2 set counts unsynchronised, clear synchronised.
// - The compare-unit special-event trigger clears the count to zero.
`timescale 1ns/10ps
module sbtc_timer #(
  parameter int INSTR_DIV = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_clock_pin_i,
  input wire logic special_event_trigger_i,
  input wire logic [7:0] port_b_direction_i,
  output logic [7:0] port_b_direction_o,
  output logic low_power_osc_enable_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] counter_control;
    logic irq_status;
    logic irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic ext_raw_prev;
    logic [7:0] icyc;
  } sbtc_state_t;
  sbtc_state_t st_ff;
  sbtc_state_t nxt_st;
  logic [15:0] count;
  logic instr_tick;
  logic ext_tick;
  logic src_tick;
  logic pre_tick;
  logic adv;
  logic wr_req;
  logic rd_req;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [15:0] count_inc;

  assign count = {st_ff.count_high_byte, st_ff.count_low_byte};
  assign idx = wb_adr_i[9:sbtc_pkg::ADDR_LSB];
  assign wbyte = wb_dat_i[7:0];
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack && wb_sel_i[0];
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !st_ff.ack;
  assign count_inc = count + sbtc_pkg::COUNT_ONE;

  // ==========================================================
  // Tick sources: instruction cycle is INSTR_DIV clocks
  assign instr_tick = (st_ff.icyc == 8'(INSTR_DIV - 1));
  // Edge of sync path, or of raw sampled pin when unsynchronised
  assign ext_tick = st_ff.counter_control[sbtc_pkg::CTL_NOSYNC]
    ? (external_count_clock_pin_i && !st_ff.ext_raw_prev)
    : (st_ff.ext_s2 && !st_ff.ext_prev);
  assign src_tick = st_ff.counter_control[sbtc_pkg::CTL_CLKSEL] ? ext_tick : instr_tick;

  sbtc_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(special_event_trigger_i),
    .tick_i(src_tick),
    .select_i({st_ff.counter_control[sbtc_pkg::CTL_PRE_HI], st_ff.counter_control[sbtc_pkg::CTL_PRE_LO]}),
    .tick_o(pre_tick)
  );
  assign adv = pre_tick && st_ff.counter_control[sbtc_pkg::CTL_ENABLE];

  // ==========================================================
  // Next-state logic: counting, bus writes, flags
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_s1 = external_count_clock_pin_i;
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.ext_prev = st_ff.ext_s2;
    nxt_st.ext_raw_prev = external_count_clock_pin_i;
    nxt_st.icyc = instr_tick ? 8'h00 : st_ff.icyc + 8'h01;
    nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
    // Counter advance; overflow flag set on wrap
    if (adv) begin
      nxt_st.count_low_byte = count_inc[7:0];
      nxt_st.count_high_byte = count_inc[15:8];
    end
    // Trigger clears count and beats a same-cycle advance
    if (special_event_trigger_i) begin
      nxt_st.count_low_byte = sbtc_pkg::BYTE_ZERO;
      nxt_st.count_high_byte = sbtc_pkg::BYTE_ZERO;
    end
    // Software writes take priority over counting
    if (wr_req) begin
      case (idx)
        sbtc_pkg::IDX_COUNT_LOW: nxt_st.count_low_byte = wbyte;
        sbtc_pkg::IDX_COUNT_HIGH: nxt_st.count_high_byte = wbyte;
        sbtc_pkg::IDX_CONTROL: nxt_st.counter_control = wbyte & sbtc_pkg::CTL_WR_MASK;
        sbtc_pkg::IDX_IRQ_STATUS: begin
          if (wbyte[sbtc_pkg::IRQ_OVF]) begin
            nxt_st.irq_status = 1'b0;
          end
        end
        sbtc_pkg::IDX_IRQ_MASK: nxt_st.irq_mask = wbyte[sbtc_pkg::IRQ_OVF];
        default: begin
        end
      endcase
    end
    // Set beats clear so an overflow during a clear is kept
    if (adv && count == sbtc_pkg::COUNT_ALL_ONES) begin
      nxt_st.irq_status = 1'b1;
    end
    // Read data captured with the request
    nxt_st.rdata = sbtc_pkg::BUS_ZERO;
    if (rd_req) begin
      case (idx)
        sbtc_pkg::IDX_COUNT_LOW: nxt_st.rdata[7:0] = st_ff.count_low_byte;
        sbtc_pkg::IDX_COUNT_HIGH: nxt_st.rdata[7:0] = st_ff.count_high_byte;
        sbtc_pkg::IDX_CONTROL: nxt_st.rdata[7:0] = st_ff.counter_control;
        sbtc_pkg::IDX_IRQ_STATUS: nxt_st.rdata[sbtc_pkg::IRQ_OVF] = st_ff.irq_status;
        sbtc_pkg::IDX_IRQ_MASK: nxt_st.rdata[sbtc_pkg::IRQ_OVF] = st_ff.irq_mask;
        default: nxt_st.rdata = sbtc_pkg::BUS_ZERO;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;
  assign irq_o = st_ff.irq_status && st_ff.irq_mask;
  // Oscillator power follows bit 3; pins 2:1 forced to input while it runs
  assign low_power_osc_enable_o = st_ff.counter_control[sbtc_pkg::CTL_OSCEN];
  assign port_b_direction_o = low_power_osc_enable_o
    ? (port_b_direction_i | sbtc_pkg::PORTB_OSC_PINS) : port_b_direction_i;

  // ==========================================================
  // Checks
  sequence s_wrap;
    adv && count == sbtc_pkg::COUNT_ALL_ONES;
  endsequence
  AST_WRAP_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wrap |=> st_ff.irq_status) else $error("overflow flag not set");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.counter_control[sbtc_pkg::CTL_ENABLE] && !special_event_trigger_i && !wr_req
    |=> count == $past(count)) else $error("count moved while disabled");
  AST_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    special_event_trigger_i && !wr_req |=> count == sbtc_pkg::COUNT_RESET) else $error("trigger no clear");
  AST_INC: assert property (@(posedge clk_i) disable iff (rst_i)
    adv && !special_event_trigger_i && !wr_req |=> count == $past(count_inc)) else $error("bad increment");
  AST_WR_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_req && idx == sbtc_pkg::IDX_COUNT_LOW |=> st_ff.count_low_byte == $past(wbyte)) else $error("low write");
  AST_WR_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_req && idx == sbtc_pkg::IDX_COUNT_HIGH |=> st_ff.count_high_byte == $past(wbyte)) else $error("high write");
  AST_TIMER_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.counter_control[sbtc_pkg::CTL_CLKSEL] && src_tick |=> !src_tick) else $error("timer tick too fast");
  AST_OSC_PINS: assert property (@(posedge clk_i) disable iff (rst_i)
    low_power_osc_enable_o |-> port_b_direction_o[2:1] == 2'b11) else $error("osc pins not inputs");
  AST_PRE8: assert property (@(posedge clk_i) disable iff (rst_i)
    pre_tick && st_ff.counter_control[5:4] == 2'b11 |=> !pre_tick [*7]) else $error("prescale 8 wrong");
  AST_SYNC: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.counter_control[sbtc_pkg::CTL_CLKSEL] && !st_ff.counter_control[sbtc_pkg::CTL_NOSYNC] && src_tick
    |-> $past(external_count_clock_pin_i, 2) && !$past(external_count_clock_pin_i, 3))
    else $error("sync edge");
  AST_PRE2: assert property (@(posedge clk_i) disable iff (rst_i)
    pre_tick && st_ff.counter_control[5:4] == 2'b01 |=> !pre_tick) else $error("prescale 2 wrong");
  AST_OSC_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctl_write |=> low_power_osc_enable_o == $past(wbyte[sbtc_pkg::CTL_OSCEN])) else $error("osc enable");

  // ==========================================================
  // Bus handshake checks
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctl_write;
    wr_req && idx == sbtc_pkg::IDX_CONTROL;
  endsequence
  sequence s_status_clear;
    wr_req && idx == sbtc_pkg::IDX_IRQ_STATUS && wbyte[sbtc_pkg::IRQ_OVF];
  endsequence

  // Every taken request is answered on the next edge
  AST_ACK_TAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take |=> wb_ack_o) else $error("request not acknowledged");

  // Ack is a single-cycle pulse; a request still held after it is taken again on the next cycle
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");

  // Only the low byte lane carries register data
  AST_RD_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper read data not zero");

  // Unmapped indices read as zero but are still acknowledged
  AST_UNMAPPED_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_req && idx != sbtc_pkg::IDX_COUNT_LOW && idx != sbtc_pkg::IDX_COUNT_HIGH
    && idx != sbtc_pkg::IDX_CONTROL && idx != sbtc_pkg::IDX_IRQ_STATUS && idx != sbtc_pkg::IDX_IRQ_MASK
    |=> wb_dat_o == sbtc_pkg::BUS_ZERO) else $error("unmapped read not zero");

  // A write without the low byte lane leaves control untouched
  AST_SEL_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take && wb_we_i && !wb_sel_i[0] && idx == sbtc_pkg::IDX_CONTROL
    |=> st_ff.counter_control == $past(st_ff.counter_control)) else $error("write without lane landed");

  // ==========================================================
  // Control and flag checks
  // The two top control bits are unimplemented and always read zero
  AST_CTL_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.counter_control[7:6] == 2'b00) else $error("control top bits set");

  // A control write lands masked on the next edge
  AST_CTL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctl_write |=> st_ff.counter_control == $past(wbyte & sbtc_pkg::CTL_WR_MASK))
    else $error("control write lost");

  // The overflow flag is sticky until software writes a one to it
  AST_IRQ_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.irq_status && !wr_req |=> st_ff.irq_status) else $error("overflow flag dropped");

  // Clearing works when no wrap falls in the same cycle
  AST_IRQ_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_status_clear && !(adv && count == sbtc_pkg::COUNT_ALL_ONES) |=> !st_ff.irq_status)
    else $error("overflow flag not cleared");

  // Set beats clear: a wrap during the clear write keeps the flag
  AST_IRQ_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
    s_status_clear and s_wrap |=> st_ff.irq_status) else $error("clear beat overflow");

  // The interrupt line never rises while the flag is masked off
  AST_IRQ_MASKED: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.irq_mask |-> !irq_o) else $error("masked interrupt raised");

  // ==========================================================
  // Prescaler checks
  // After a trigger the prescaler restarts, so a divided tick cannot follow at once
  AST_PRE_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    special_event_trigger_i && st_ff.counter_control[5:4] != 2'b00 && !wr_req |=> !pre_tick)
    else $error("prescaler not cleared");

  // Divide by four leaves three quiet cycles at least
  AST_PRE4: assert property (@(posedge clk_i) disable iff (rst_i)
    pre_tick && st_ff.counter_control[5:4] == 2'b10 |=> !pre_tick [*3]) else $error("prescale 4 wrong");

  // Pass-through code follows the selected source tick for tick
  AST_PRE1: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.counter_control[5:4] == 2'b00 && !special_event_trigger_i |-> pre_tick == src_tick)
    else $error("prescale 1 wrong");

  // Timer mode never counts faster than one instruction cycle
  AST_INSTR_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_tick |=> !instr_tick [*3]) else $error("instruction tick too fast");
endmodule // sbtc_timer

// ### tb/sbtc_ext_clock_model.sv
// Model of the far side of the external count pin: a slow clock source.
// Assumes the bench calls burst from its own process, clocked by clk_i.
`timescale 1ns/10ps
module sbtc_ext_clock_model (
  input wire logic clk_i,
  output logic ext_clk_o
);
  // ==========================================
  // Pin rests low between bursts, so no stray edge is ever counted
  initial ext_clk_o = 1'b0;
  // Each pulse is h clocks high and h low; h sets a prompt or slow source
  task automatic burst(input int n, input int h);
    for (int i = 0; i < n; i++) begin
      repeat (h) @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (h) @(posedge clk_i);
      ext_clk_o <= 1'b0;
    end
  endtask
endmodule // sbtc_ext_clock_model

// ### tb/tb_sixteen_bit_timer_counter.sv
// Self-checking bench of the timer/counter, registers reached over Wishbone.
// Assumes the external pin model above and one 25 MHz clock.
`timescale 1ns/10ps
module tb_sixteen_bit_timer_counter;
  localparam int DIV = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, trig = 1'b0, osc, irq, ext;
  logic [7:0] dir_i = 8'h00;
  logic [7:0] dir_o, q;
  logic [15:0] v, w;
  int err_total = 0;
  int checks = 0;
  // ==========================================
  // Design, far-side pin model and clock
  sbtc_timer #(.INSTR_DIV(DIV)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_count_clock_pin_i(ext), .special_event_trigger_i(trig), .port_b_direction_i(dir_i),
    .port_b_direction_o(dir_o), .low_power_osc_enable_o(osc), .irq_o(irq));
  sbtc_ext_clock_model ext_src (.clk_i(clk_i), .ext_clk_o(ext));
  always #20 clk_i = ~clk_i;
  // ==========================================
  // Expected tick count over n clocks with prescale code c
  function automatic int ticks(input int n, input int c);
    return n / (DIV << c);
  endfunction
  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Range compare; an unknown bit never passes
  task automatic chk(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
    checks++;
    if ((^g) === 1'bx || g < lo || g > hi) begin
      err_total++;
      $display("BAD %0t got %h expected %h..%h", $time, g, lo, hi);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic bus(input logic w_en, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 64) begin
      err_total++;
      $display("BAD %0t no acknowledge", $time);
      summarize();
    end
  endtask
  task automatic rd16(output logic [15:0] r);
    bus(1'b0, sbtc_pkg::IDX_COUNT_HIGH, 8'h00, r[15:8]);
    bus(1'b0, sbtc_pkg::IDX_COUNT_LOW, 8'h00, r[7:0]);
  endtask
  task automatic pulse();
    @(posedge clk_i);
    trig <= 1'b1;
    @(posedge clk_i);
    trig <= 1'b0;
  endtask
  // Lets registered flags land before they are looked at
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // ==========================================
  // Bound on the whole run, in case a wait inside the design hangs
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    $display("BAD %0t run limit reached", $time);
    summarize();
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h415916c7));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, sbtc_pkg::IDX_CONTROL, 8'h00, q);
    chk({8'h00, q}, 16'h0000, 16'h0000);
    rd16(v);
    chk(v, 16'h0000, 16'h0000);
    chk({15'h0000, irq}, 16'h0000, 16'h0000);
    $display("Test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      bus(1'b1, sbtc_pkg::IDX_COUNT_LOW, v[7:0], q);
      bus(1'b1, sbtc_pkg::IDX_COUNT_HIGH, v[15:8], q);
      rd16(w);
      chk(w, v, v);
    end
    bus(1'b1, sbtc_pkg::IDX_CONTROL, 8'hff, q);
    bus(1'b0, sbtc_pkg::IDX_CONTROL, 8'h00, q);
    chk({8'h00, q}, 16'h003f, 16'h003f);
    bus(1'b1, sbtc_pkg::IDX_CONTROL, 8'h00, q);
    bus(1'b0, 8'h30, 8'h00, q);
    chk({8'h00, q}, 16'h0000, 16'h0000);
    $display("Test registers done");
    // Every prescale code, then hold while stopped, then trigger clear
    for (int c = 0; c < 4; c++) begin
      pulse();
      bus(1'b1, sbtc_pkg::IDX_CONTROL, {2'b00, 2'(c), 4'h1}, q);
      repeat (80 << c) @(posedge clk_i);
      bus(1'b1, sbtc_pkg::IDX_CONTROL, {2'b00, 2'(c), 4'h0}, q);
      rd16(v);
      chk(v, 16'(ticks(80 << c, c) - 1), 16'(ticks(80 << c, c) + 1));
      repeat (40) @(posedge clk_i);
      rd16(w);
      chk(w, v, v);
      pulse();
      rd16(w);
      chk(w, 16'h0000, 16'h0000);
    end
    $display("Test prescaler done");
    // Wrap from all ones, then mask and clear the sticky flag
    bus(1'b1, sbtc_pkg::IDX_COUNT_LOW, 8'hfd, q);
    bus(1'b1, sbtc_pkg::IDX_COUNT_HIGH, 8'hff, q);
    bus(1'b1, sbtc_pkg::IDX_IRQ_MASK, 8'h01, q);
    bus(1'b1, sbtc_pkg::IDX_CONTROL, 8'h01, q);
    repeat (40) @(posedge clk_i);
    bus(1'b1, sbtc_pkg::IDX_CONTROL, 8'h00, q);
    settle();
    chk({15'h0000, irq}, 16'h0001, 16'h0001);
    rd16(v);
    chk(v, 16'h0001, 16'h000c);
    bus(1'b1, sbtc_pkg::IDX_IRQ_MASK, 8'h00, q);
    settle();
    chk({15'h0000, irq}, 16'h0000, 16'h0000);
    bus(1'b0, sbtc_pkg::IDX_IRQ_STATUS, 8'h00, q);
    chk({8'h00, q}, 16'h0001, 16'h0001);
    bus(1'b1, sbtc_pkg::IDX_IRQ_MASK, 8'h01, q);
    bus(1'b1, sbtc_pkg::IDX_IRQ_STATUS, 8'h01, q);
    settle();
    chk({15'h0000, irq}, 16'h0000, 16'h0000);
    $display("Test overflow done");
    // External edges, synchronised then unsynchronised, fast then slow
    for (int s = 0; s < 2; s++) begin
      pulse();
      bus(1'b1, sbtc_pkg::IDX_CONTROL, {5'h00, 1'(s), 2'h3}, q);
      ext_src.burst(10, 3 + 3 * s);
      repeat (8) @(posedge clk_i);
      bus(1'b1, sbtc_pkg::IDX_CONTROL, 8'h00, q);
      rd16(v);
      chk(v, 16'h000a, 16'h000a);
    end
    $display("Test counter done");
    // Oscillator enable takes over port B pins 2 and 1
    @(posedge clk_i);
    dir_i <= 8'($urandom);
    bus(1'b1, sbtc_pkg::IDX_CONTROL, 8'h08, q);
    settle();
    chk({15'h0000, osc}, 16'h0001, 16'h0001);
    chk({8'h00, dir_o}, {8'h00, dir_i | 8'h06}, {8'h00, dir_i | 8'h06});
    bus(1'b1, sbtc_pkg::IDX_CONTROL, 8'h00, q);
    settle();
    chk({15'h0000, osc}, 16'h0000, 16'h0000);
    chk({8'h00, dir_o}, {8'h00, dir_i}, {8'h00, dir_i});
    $display("Test oscillator done");
    summarize();
  end
endmodule // tb_sixteen_bit_timer_counter
